/* hdl/msd_regs.v */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "msd_regs.vh"

// Contract
// - Spacing mantissa resets to 0xf8, spacing is fref/2^18*(256+m)<<e.
// - Frequency is the base plus channel number times spacing.
// - Spacing exponent is bits 1:0 of the modem config, reset binary 10.
// - Deviation resets to e=100, m=111, and is fref/2^17*(8+m)<<e.
// - FSK or GFSK transmit shifts by -deviation for 0 and +deviation for 1.
// - MSK transmit uses it as 1/8..8/8 phase time, +90 on 0, -90 deg on 1.
// - Deviation is ignored for ASK transmit and for MSK or ASK receive.
// - FSK or GFSK receive takes it as the expected incoming deviation.
module msd_regs
#(
  parameter BASE_W = 24,
  parameter OUT_W  = 27
)
(
  // Clock and reset
  input  wire                clk_sys,
  input  wire                resetn,
  // Register port
  input  wire [15:0]         reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata,
  // Modem context
  input  wire [BASE_W-1:0]   base_freq,
  input  wire [7:0]          channel_number,
  input  wire [1:0]          mod_format,
  input  wire                tx_mode,
  input  wire                tx_bit,
  // Derived settings
  output reg  [OUT_W-1:0]    freq_word_q,
  output reg  [11:0]         tx_offset_q,
  output reg  [3:0]          msk_frac_q,
  output reg                 msk_phase_neg_q,
  output reg  [10:0]         rx_dev_q,
  output reg                 rx_dev_valid_q
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg  [1:0]        spacing_exponent_q;
  reg  [7:0]        spacing_mantissa_q;
  reg  [2:0]        dev_exp_q;
  reg  [2:0]        dev_mant_q;

  wire              sel_cfg;
  wire              sel_mant;
  wire              sel_dev;

  assign sel_cfg  = (reg_addr == `MSD_OFS_MODEM_CFG);
  assign sel_mant = (reg_addr == `MSD_OFS_SPACING_MANT);
  assign sel_dev  = (reg_addr == `MSD_OFS_DEVIATION);

  // Next values; each register reloads itself unless written
  reg  [1:0]        spacing_exponent_d;
  reg  [7:0]        spacing_mantissa_d;
  reg  [2:0]        dev_exp_d;
  reg  [2:0]        dev_mant_d;

  // Writes to unmapped offsets change nothing
  always @*
  begin
    spacing_exponent_d = spacing_exponent_q;
    spacing_mantissa_d = spacing_mantissa_q;
    dev_exp_d          = dev_exp_q;
    dev_mant_d         = dev_mant_q;
    if (reg_wr && sel_cfg)
    begin
      spacing_exponent_d =
        reg_wdata[`MSD_SPACING_EXP_MSB:`MSD_SPACING_EXP_LSB];
    end
    if (reg_wr && sel_mant)
    begin
      spacing_mantissa_d = reg_wdata;
    end
    if (reg_wr && sel_dev)
    begin
      dev_exp_d  = reg_wdata[`MSD_DEV_EXP_MSB:`MSD_DEV_EXP_LSB];
      dev_mant_d = reg_wdata[`MSD_DEV_MANT_MSB:`MSD_DEV_MANT_LSB];
    end
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      spacing_exponent_q <= `MSD_RST_SPACING_EXP;
    end
    else
    begin
      spacing_exponent_q <= spacing_exponent_d;
    end
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      spacing_mantissa_q <= `MSD_RST_SPACING_MANT;
    end
    else
    begin
      spacing_mantissa_q <= spacing_mantissa_d;
    end
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dev_exp_q  <= `MSD_RST_DEV_EXP;
      dev_mant_q <= `MSD_RST_DEV_MANT;
    end
    else
    begin
      dev_exp_q  <= dev_exp_d;
      dev_mant_q <= dev_mant_d;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped addresses read zero
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      if (sel_cfg)
      begin
        reg_rdata <= {6'h00, spacing_exponent_q};
      end
      else if (sel_mant)
      begin
        reg_rdata <= spacing_mantissa_q;
      end
      else if (sel_dev)
      begin
        reg_rdata <= {1'h0, dev_exp_q, 1'h0, dev_mant_q};
      end
      else
      begin
        reg_rdata <= 8'h00;
      end
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Spacing and frequency
  // ----------------------------------------
  // Units of fref/2^18; base given in fref/2^16
  wire [11:0]       spacing;
  wire [19:0]       channel_offset;
  wire [OUT_W-1:0]  freq_d;

  assign spacing = {3'h0, 1'h1, spacing_mantissa_q} << spacing_exponent_q;

  assign channel_offset = {12'h000, channel_number} * {8'h00, spacing};
  assign freq_d = {{(OUT_W-BASE_W-2){1'h0}}, base_freq, 2'h0}
                + {{(OUT_W-20){1'h0}}, channel_offset};

  // ----------------------------------------
  // Deviation
  // ----------------------------------------
  // Units of fref/2^17
  wire [10:0]       deviation;
  wire              is_fsk;
  wire              is_msk;
  wire              fsk_tx;
  wire              msk_tx;
  wire              fsk_rx;
  wire [11:0]       dev_signed;
  wire [11:0]       tx_offset_d;
  wire [3:0]        msk_frac_d;
  wire              msk_phase_neg_d;
  wire [10:0]       rx_dev_d;
  wire              rx_dev_valid_d;

  assign deviation = {7'h00, 1'h1, dev_mant_q} << dev_exp_q;

  assign is_fsk = (mod_format == `MSD_MOD_2FSK) ||
                  (mod_format == `MSD_MOD_GFSK);
  assign is_msk = (mod_format == `MSD_MOD_MSK);
  assign fsk_tx = tx_mode && is_fsk;
  assign msk_tx = tx_mode && is_msk;
  // ASK either way and MSK receive fall through
  assign fsk_rx = !tx_mode && is_fsk;

  assign dev_signed = tx_bit ? {1'h0, deviation}
                             : (12'h000 - {1'h0, deviation});
  assign tx_offset_d = fsk_tx ? dev_signed : 12'h000;
  assign msk_frac_d      = msk_tx ? ({1'h0, dev_mant_q} + 4'h1) : 4'h0;
  assign msk_phase_neg_d = msk_tx && tx_bit;
  // MSK or ASK receive ignores it
  assign rx_dev_d        = fsk_rx ? deviation : 11'h000;
  assign rx_dev_valid_d  = fsk_rx;

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // frequency word
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      freq_word_q <= {OUT_W{1'h0}};
    end
    else
    begin
      freq_word_q <= freq_d;
    end
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_offset_q <= 12'h000;
    end
    else
    begin
      tx_offset_q <= tx_offset_d;
    end
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      msk_frac_q <= 4'h0;
    end
    else
    begin
      msk_frac_q <= msk_frac_d;
    end
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      msk_phase_neg_q <= 1'h0;
    end
    else
    begin
      msk_phase_neg_q <= msk_phase_neg_d;
    end
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_dev_q <= 11'h000;
    end
    else
    begin
      rx_dev_q <= rx_dev_d;
    end
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_dev_valid_q <= 1'h0;
    end
    else
    begin
      rx_dev_valid_q <= rx_dev_valid_d;
    end
  end

endmodule

/* inc/msd_regs.vh */
`ifndef MSD_REGS_VH
`define MSD_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MSD_OFS_MODEM_CFG      16'hdf0f
`define MSD_OFS_SPACING_MANT   16'hdf10
`define MSD_OFS_DEVIATION      16'hdf11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MSD_RST_SPACING_EXP    2'h2
`define MSD_RST_SPACING_MANT   8'hf8
`define MSD_RST_DEV_EXP        3'h4
`define MSD_RST_DEV_MANT       3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSD_SPACING_EXP_LSB    0
`define MSD_SPACING_EXP_MSB    1
`define MSD_DEV_MANT_LSB       0
`define MSD_DEV_MANT_MSB       2
`define MSD_DEV_EXP_LSB        4
`define MSD_DEV_EXP_MSB        6

// ----------------------------------------
// Modulation codes
// ----------------------------------------
`define MSD_MOD_2FSK           2'h0
`define MSD_MOD_GFSK           2'h1
`define MSD_MOD_ASK            2'h2
`define MSD_MOD_MSK            2'h3

`endif

/* verif/msd_regs_asserts.sv */
`timescale 1ns/10ps
module msd_regs_asserts #(parameter BASE_W = 24, OUT_W = 27) (
  input wire              clk_sys, resetn, reg_wr, reg_rd, tx_mode, tx_bit,
  input wire [15:0]       reg_addr,
  input wire [7:0]        reg_wdata, reg_rdata, channel_number,
  input wire [BASE_W-1:0] base_freq,
  input wire [1:0]        mod_format,
  input wire [OUT_W-1:0]  freq_word_q,
  input wire [11:0]       tx_offset_q,
  input wire [3:0]        msk_frac_q,
  input wire              msk_phase_neg_q, rx_dev_valid_q,
  input wire [10:0]       rx_dev_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire fsk = !mod_format[1];
  wire msk = mod_format == 2'h3;
  // Three quiet edges, so reset release never looks unstable
  sequence quiet;
    !reg_wr && $stable(base_freq) && $stable(channel_number);
  endsequence
  a_cfg_rsvd: assert property (reg_rd && reg_addr == 16'hdf0f
    |=> reg_rdata[7:2] == 6'h0) else $error("cfg spare bits set");
  a_dev_rsvd: assert property (reg_rd && reg_addr == 16'hdf11
    |=> !reg_rdata[7] && !reg_rdata[3]) else $error("dev spare bits set");
  a_fsk_sign: assert property (fsk && tx_mode
    |=> tx_offset_q != 12'h0 && tx_offset_q[11] == !$past(tx_bit))
    else $error("fsk offset sign");
  a_ask_zero: assert property (mod_format == 2'h2
    |=> tx_offset_q == 12'h0 && msk_frac_q == 4'h0) else $error("ask dev");
  a_msk_frac: assert property (msk && tx_mode
    |=> msk_frac_q inside {[1:8]} && msk_phase_neg_q == $past(tx_bit))
    else $error("msk fraction");
  a_rx_ignore: assert property (!fsk && !tx_mode
    |=> rx_dev_q == 11'h0 && !rx_dev_valid_q) else $error("rx dev used");
  a_rx_valid: assert property (fsk && !tx_mode
    |=> rx_dev_valid_q && rx_dev_q != 11'h0) else $error("rx dev missing");
  a_freq_hold: assert property (quiet [*3] |-> $stable(freq_word_q))
    else $error("freq word moved");
endmodule
bind msd_regs msd_regs_asserts #(.BASE_W(BASE_W), .OUT_W(OUT_W)) i_chk (.*);

/* verif/msd_regs_tb.sv */
`timescale 1ns/10ps
module msd_regs_tb;
  reg         clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  reg         tx_mode = 1, tx_bit = 1;
  reg  [15:0] reg_addr = 16'h0;
  reg  [7:0]  reg_wdata = 8'h0, channel_number = 8'h3;
  reg  [23:0] base_freq = 24'h1000;
  reg  [1:0]  mod_format = 2'h0;
  wire [7:0]  reg_rdata;
  wire [26:0] freq_word_q;
  wire [11:0] tx_offset_q;
  wire [3:0]  msk_frac_q;
  wire        msk_phase_neg_q, rx_dev_valid_q;
  wire [10:0] rx_dev_q;
  integer     err_total = 0, checks = 0, i;
  msd_regs i_dut (.*);
  always #5 clk_sys = ~clk_sys;
  task final_report;
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input [31:0] seen, exp, input string nm);
    checks = checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input [15:0] a, input [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, "rdata");
  endtask
  task t_reset;
    rd(16'hdf0f, 8'h02);
    rd(16'hdf10, 8'hf8);
    rd(16'hdf11, 8'h47);
    rd(16'hdf12, 8'h00);
    // Spacing 0x1f8 << 2 on base 0x1000 * 4, channel 3
    chk(freq_word_q, 27'h57a0, "freq");
    chk(tx_offset_q, 12'hf0, "offset");
  endtask
  task t_regs;
    wr(16'hdf10, 8'h00);
    wr(16'hdf0f, 8'hff);
    wr(16'hdf11, 8'hff);
    rd(16'hdf11, 8'h77);
    chk(tx_offset_q, 12'h780, "offset");
    rd(16'hdf0f, 8'h03);
    chk(freq_word_q, 27'h5800, "freq");
    @(posedge clk_sys);
    channel_number <= 8'h5;
    wr(16'hdf11, 8'h08);
    rd(16'hdf11, 8'h00);
    chk(freq_word_q, 27'h6800, "freq");
  endtask
  // Smallest deviation, so fraction sits at its low end
  task t_mod;
    for (i = 0; i < 16; i = i + 1)
    begin
      @(posedge clk_sys);
      mod_format <= i[1:0];
      tx_mode <= i[2];
      tx_bit <= i[3];
      repeat (2) @(posedge clk_sys);
      #1;
      chk(tx_offset_q, !i[1] && i[2] ? (i[3] ? 8 : 12'hff8) : 0, "ofs");
      chk(msk_frac_q, (i[1:0] == 3 && i[2]) ? 1 : 0, "frac");
      chk(msk_phase_neg_q, i[1:0] == 3 && i[2] && i[3], "phase");
      chk(rx_dev_q, (!i[1] && !i[2]) ? 8 : 0, "rxdev");
      chk(rx_dev_valid_q, !i[1] && !i[2], "rxval");
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_regs;
    t_mod;
    final_report;
  end
  initial
  begin
    #100000;
    err_total = err_total + 1;
    final_report;
  end
endmodule
